//--- verilog/lan_window_access.sv
// Host register access for the LAN controller: command/status, configuration,
// pointers and the indirect buffer window with station addresses, PROM and vector.
// Assumes host strobes and memory/receiver signals are synchronous to clk.
//
// Contract
// - Six window reads return the selected station address, low byte first.
// - Two-byte matching uses two bytes; all six stay readable and writable.
// - Transmit end value bounds transmit pointer and loading window address high byte.
// - Receive start high byte equals transmit end value plus one.
// - Interrupt vector is read/write through the window at target code nine.
// - Acknowledge cycle drives the stored vector onto data bits 7..0, except while a PROM access holds the data pins.
// - Bus style 0: request high, acknowledge low, read/write high.
// - Bus style 1: request high, acknowledge low, I/O read strobe low.
// - PROM address goes out on data bits 15..8 from the window address.
// - PROM data is captured from data bits 7..0.
// - PROM chip select asserts on each window access while targeting the PROM.
// - Receive header status: bit 7 zero, bit 6 chain continue, rest zero.
// - Window address supplies location for buffer memory and PROM targets.
// - Transmit end value sits in the indirect register at code seven.
`timescale 1ns/1ps

module lan_window_access
	import lan_window_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [15:0]      reg_rdata,
	output logic             reg_rvalid,
	input  wire logic        bus_style_select,
	input  wire logic        int_active,
	input  wire logic        interrupt_ack_n,
	input  wire logic        read_write,
	input  wire logic        io_read_strobe_n,
	input  wire logic [15:0] data_in,
	output logic [15:0]      data_out,
	output logic             data_oe_hi,
	output logic             data_oe_lo,
	output logic             prom_chip_select_n,
	output logic [15:0]      mem_addr,
	output logic [7:0]       mem_wdata,
	output logic             mem_we,
	output logic             mem_re,
	input  wire logic [7:0]  mem_rdata,
	input  wire logic        rx_stopped,
	input  wire logic        hdr_store,
	input  wire logic        hdr_last,
	input  wire logic [15:0] hdr_next_ptr,
	output logic [15:0]      hdr_ptr,
	output logic [7:0]       hdr_status,
	output logic [7:0]       rx_start_high,
	output logic [5:0]       station_enable,
	output logic             addr_two_byte,
	output logic             tx_on,
	output logic             rx_on,
	output logic             dma_on
);

	logic [15:0]   cfg1_r;
	logic [15:0]   cfg2_r;
	logic [7:0]    rea_r;
	logic [7:0]    tea_r;
	logic [7:0]    vec_r;
	logic [15:0]   rx_ptr_r;
	logic [15:0]   tx_ptr_r;
	logic [15:0]   dma_r;
	logic [2:0]    byte_idx_r;
	logic [7:0]    station_r [STATION_COUNT*STATION_BYTES];
	access_state_t state_r;
	logic [1:0]    ext_cnt_r;
	logic          ext_is_prom_r;

	logic [3:0]    code;
	logic          win_acc;
	logic          station_sel;
	logic          ext_sel;
	logic          ack_cycle;
	logic [5:0]    st_index;

	// Transmit end bound on an address high byte
	function automatic logic [7:0] bound_high(input logic [7:0] hi, input logic [7:0] lim);
		bound_high = (hi > lim) ? lim : hi;
	endfunction

	// Window address step with wrap by direction
	function automatic logic [15:0] dma_step(input logic [15:0] a, input logic wr,
		input logic [7:0] lim);
		if (wr && a == {lim, 8'hFF})
			dma_step = 16'h0000;
		else if (!wr && a == 16'hFFFF)
			dma_step = {8'(lim + 8'h01), 8'h00};
		else
			dma_step = 16'(a + 16'h0001);
	endfunction

	assign code        = cfg1_r[CFG1_CODE_LSB +: 4];
	assign win_acc     = (reg_wr || reg_rd) && reg_addr[3:1] == SEL_WINDOW
		&& state_r == ST_IDLE;
	assign station_sel = code <= CODE_LAST_STATION;
	assign ext_sel     = code == CODE_PROM || code == CODE_MEMORY;
	assign st_index    = 6'(code[2:0] * STATION_BYTES + byte_idx_r);
	assign ack_cycle   = int_active && !interrupt_ack_n
		&& (bus_style_select ? !io_read_strobe_n : read_write);

	// Direct configuration and pointer registers
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			cfg1_r   <= CFG1_RESET;
			cfg2_r   <= CFG2_RESET;
			rea_r    <= 8'h00;
			rx_ptr_r <= 16'h0000;
			tx_ptr_r <= 16'h0000;
		end
		else if (reg_wr)
		begin
			case (reg_addr[3:1])
				SEL_CFG1:   cfg1_r   <= reg_wdata;
				SEL_CFG2:   cfg2_r   <= reg_wdata;
				SEL_REA:    rea_r    <= reg_wdata[7:0];
				SEL_RX_PTR: rx_ptr_r <= reg_wdata;
				SEL_TX_PTR: tx_ptr_r <= {bound_high(reg_wdata[15:8], tea_r), reg_wdata[7:0]};
				default:    ;
			endcase
		end
	end

	// Section on/off from command writes
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			tx_on  <= 1'b0;
			rx_on  <= 1'b0;
			dma_on <= 1'b0;
		end
		else
		begin
			if (reg_wr && reg_addr[3:1] == SEL_CMD_STAT)
			begin
				if (reg_wdata[CMD_TX_OFF])
					tx_on <= 1'b0;
				else if (reg_wdata[CMD_TX_ON])
					tx_on <= 1'b1;
				if (reg_wdata[CMD_DMA_OFF])
					dma_on <= 1'b0;
				else if (reg_wdata[CMD_DMA_ON])
					dma_on <= 1'b1;
			end
			// Receiver stop wins over a simultaneous on command
			if (rx_stopped)
				rx_on <= 1'b0;
			else if (reg_wr && reg_addr[3:1] == SEL_CMD_STAT)
			begin
				if (reg_wdata[CMD_RX_OFF])
					rx_on <= 1'b0;
				else if (reg_wdata[CMD_RX_ON])
					rx_on <= 1'b1;
			end
		end
	end

	// Indirect byte registers and the station byte counter
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			tea_r      <= TEA_RESET;
			vec_r      <= VEC_RESET;
			byte_idx_r <= 3'h0;
		end
		else if (reg_wr && reg_addr[3:1] == SEL_CFG1)
			byte_idx_r <= 3'h0;
		else if (win_acc)
		begin
			if (station_sel)
			begin
				if (reg_wr)
					station_r[st_index] <= reg_wdata[7:0];
				byte_idx_r <= (byte_idx_r == 3'(STATION_BYTES - 1)) ? 3'h0
					: 3'(byte_idx_r + 3'h1);
			end
			if (reg_wr && code == CODE_TX_END)
				tea_r <= reg_wdata[7:0];
			if (reg_wr && code == CODE_VECTOR)
				vec_r <= reg_wdata[7:0];
		end
	end

	// Window address register and external access sequencing
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			dma_r         <= 16'h0000;
			state_r       <= ST_IDLE;
			ext_cnt_r     <= 2'h0;
			ext_is_prom_r <= 1'b0;
		end
		else
		begin
			case (state_r)
				ST_IDLE:
				begin
					if (reg_wr && reg_addr[3:1] == SEL_DMA)
						dma_r <= reg_wdata;
					else if (win_acc && ext_sel)
					begin
						state_r       <= ST_EXT;
						ext_cnt_r     <= 2'(EXT_CYCLES - 1);
						ext_is_prom_r <= code == CODE_PROM;
					end
				end
				ST_EXT:
				begin
					if (ext_cnt_r == 2'h0)
						state_r <= ST_DONE;
					else
						ext_cnt_r <= 2'(ext_cnt_r - 2'h1);
				end
				ST_DONE:
				begin
					state_r <= ST_IDLE;
					if (ext_is_prom_r)
						dma_r <= {8'h00, 8'(dma_r[7:0] + 8'h01)};
					// wrap at transmit end on loading
					else
						dma_r <= dma_step(dma_r, mem_we, tea_r);
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// Buffer memory strobes and host-side answer
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			mem_addr   <= 16'h0000;
			mem_wdata  <= 8'h00;
			mem_we     <= 1'b0;
			mem_re     <= 1'b0;
			reg_rdata  <= 16'h0000;
			reg_rvalid <= 1'b0;
		end
		else
		begin
			reg_rvalid <= 1'b0;
			if (win_acc && code == CODE_MEMORY)
			begin
				mem_addr  <= reg_wr ? {bound_high(dma_r[15:8], tea_r), dma_r[7:0]} : dma_r;
				mem_wdata <= reg_wdata[7:0];
				mem_we    <= reg_wr;
				mem_re    <= reg_rd;
			end
			else if (state_r == ST_DONE)
			begin
				mem_we <= 1'b0;
				mem_re <= 1'b0;
			end
			if (state_r == ST_DONE && !mem_we)
			begin
				reg_rvalid <= 1'b1;
				reg_rdata  <= {8'h00, ext_is_prom_r ? data_in[7:0] : mem_rdata};
			end
			else if (reg_rd && state_r == ST_IDLE && !(win_acc && ext_sel))
			begin
				reg_rvalid <= 1'b1;
				case (reg_addr[3:1])
					SEL_CMD_STAT: reg_rdata <= 16'({tx_on, rx_on, dma_on}) << STAT_ON_LSB;
					SEL_CFG1:     reg_rdata <= cfg1_r;
					SEL_CFG2:     reg_rdata <= cfg2_r;
					SEL_REA:      reg_rdata <= {8'h00, rea_r};
					SEL_RX_PTR:   reg_rdata <= rx_ptr_r;
					SEL_TX_PTR:   reg_rdata <= tx_ptr_r;
					SEL_DMA:      reg_rdata <= dma_r;
					SEL_WINDOW:
					begin
						if (station_sel)
							reg_rdata <= {8'h00, station_r[st_index]};
						else if (code == CODE_TX_END)
							reg_rdata <= {8'h00, tea_r};
						else if (code == CODE_VECTOR)
							reg_rdata <= {8'h00, vec_r};
						else
							reg_rdata <= 16'h0000;
					end
					default:      reg_rdata <= 16'h0000;
				endcase
			end
		end
	end

	// Shared data pins: acknowledge vector or PROM address
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			data_out           <= 16'h0000;
			data_oe_hi         <= 1'b0;
			data_oe_lo         <= 1'b0;
			prom_chip_select_n <= 1'b1;
		end
		else if (win_acc && code == CODE_PROM)
		begin
			data_out           <= {dma_r[7:0], 8'h00};
			data_oe_hi         <= 1'b1;
			data_oe_lo         <= 1'b0;
			prom_chip_select_n <= 1'b0;
		end
		else if (state_r == ST_DONE || (state_r == ST_EXT && !ext_is_prom_r)
			|| state_r == ST_IDLE)
		begin
			data_oe_hi <= 1'b0;
			if (state_r != ST_EXT)
				prom_chip_select_n <= 1'b1;
			data_oe_lo <= ack_cycle;
			data_out   <= ack_cycle ? {8'h00, vec_r} : 16'h0000;
		end
	end

	// Receive frame header bytes
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			hdr_ptr    <= 16'h0000;
			hdr_status <= 8'h00;
		end
		else if (hdr_store)
		begin
			hdr_ptr    <= hdr_last ? 16'h0000 : hdr_next_ptr;
			// bit 7 zero, chain flag bit 6
			hdr_status <= 8'(!hdr_last) << HDR_CHAIN_BIT;
		end
	end

	// Register copies and the derived receive start for the receive and matching logic
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			rx_start_high  <= 8'h01;
			station_enable <= 6'h00;
			addr_two_byte  <= 1'b0;
		end
		else
		begin
			// receive start = end + 1
			rx_start_high  <= 8'(tea_r + 8'h01);
			station_enable <= cfg1_r[CFG1_STA_LSB +: 6];
			addr_two_byte  <= cfg2_r[CFG2_TWO_BYTE];
		end
	end

endmodule

//--- verilog/lan_window_pkg.sv
// Constants for the buffer-window register access block.
// Assumes one 100 MHz clock shared with the host strobes.
package lan_window_pkg;

	// Register select, address bits 3..1
	localparam logic [2:0] SEL_CMD_STAT = 3'h0;
	localparam logic [2:0] SEL_CFG1     = 3'h1;
	localparam logic [2:0] SEL_CFG2     = 3'h2;
	localparam logic [2:0] SEL_REA      = 3'h3;
	localparam logic [2:0] SEL_WINDOW   = 3'h4;
	localparam logic [2:0] SEL_RX_PTR   = 3'h5;
	localparam logic [2:0] SEL_TX_PTR   = 3'h6;
	localparam logic [2:0] SEL_DMA      = 3'h7;

	// Window target codes
	localparam logic [3:0] CODE_LAST_STATION = 4'h5;
	localparam logic [3:0] CODE_PROM         = 4'h6;
	localparam logic [3:0] CODE_TX_END       = 4'h7;
	localparam logic [3:0] CODE_MEMORY       = 4'h8;
	localparam logic [3:0] CODE_VECTOR       = 4'h9;

	// Command bit positions
	localparam int CMD_DMA_ON  = 8;
	localparam int CMD_RX_ON   = 9;
	localparam int CMD_TX_ON   = 10;
	localparam int CMD_DMA_OFF = 11;
	localparam int CMD_RX_OFF  = 12;
	localparam int CMD_TX_OFF  = 13;

	// Field positions
	localparam int CFG1_CODE_LSB = 0;
	localparam int CFG1_STA_LSB  = 8;
	localparam int CFG2_TWO_BYTE = 8;
	localparam int STAT_ON_LSB   = 8;
	localparam int HDR_CHAIN_BIT = 6;

	// Reset values
	localparam logic [15:0] CFG1_RESET = 16'h0000;
	localparam logic [15:0] CFG2_RESET = 16'h0000;
	localparam logic [7:0]  TEA_RESET  = 8'h00;
	localparam logic [7:0]  VEC_RESET  = 8'h00;

	localparam int STATION_COUNT = 6;
	localparam int STATION_BYTES = 6;

	// External access (PROM, buffer memory) strobe time
	localparam int CLK_PERIOD_NS  = 10;
	localparam int EXT_ACCESS_NS  = 20;
	localparam int EXT_CYCLES     = (EXT_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [1:0]
	{
		ST_IDLE  = 2'b00,
		ST_EXT   = 2'b01,
		ST_DONE  = 2'b10
	} access_state_t;

endpackage

//--- tb/lan_window_access_asserts.sv
// Port checker for the window block: ack vectoring, PROM strobe, header bytes.
// Assumes it is bound into lan_window_access.
`timescale 1ns/1ps
module lan_window_access_asserts
	import lan_window_pkg::*;
(
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic        reg_rvalid,
	input wire logic        bus_style_select,
	input wire logic        int_active,
	input wire logic        interrupt_ack_n,
	input wire logic        read_write,
	input wire logic        io_read_strobe_n,
	input wire logic [15:0] data_in,
	input wire logic        data_oe_hi,
	input wire logic        data_oe_lo,
	input wire logic        prom_chip_select_n,
	input wire logic        hdr_store,
	input wire logic        hdr_last,
	input wire logic [15:0] hdr_next_ptr,
	input wire logic [15:0] hdr_ptr,
	input wire logic [7:0]  hdr_status,
	input wire logic        rx_stopped,
	input wire logic        rx_on
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic ack_cyc;
	assign ack_cyc = int_active && !interrupt_ack_n
		&& (bus_style_select ? !io_read_strobe_n : read_write);

	a_ack_vector_on: assert property (ack_cyc && prom_chip_select_n |=> data_oe_lo)
		else $error("vector not driven in ack cycle");
	a_ack_vector_off: assert property (!ack_cyc |=> !data_oe_lo)
		else $error("vector driven outside ack cycle");
	a_prom_addr_out: assert property (!prom_chip_select_n |-> data_oe_hi)
		else $error("PROM selected without address");
	a_prom_select_span: assert property ($fell(prom_chip_select_n)
		|-> !prom_chip_select_n [*3] ##1 prom_chip_select_n)
		else $error("PROM select length wrong");
	a_prom_data_capture: assert property ($fell(prom_chip_select_n) && $past(reg_rd)
		|-> ##3 reg_rvalid && reg_rdata == {8'h00, $past(data_in[7:0])})
		else $error("PROM byte not returned");
	a_hdr_chain_on: assert property (hdr_store && !hdr_last
		|=> hdr_status == 8'h40 && hdr_ptr == $past(hdr_next_ptr))
		else $error("chained header wrong");
	a_hdr_chain_end: assert property (hdr_store && hdr_last
		|=> hdr_status == 8'h00 && hdr_ptr == 16'h0000)
		else $error("closing header not zero");
	a_rx_stop_clears: assert property (rx_stopped |=> !rx_on)
		else $error("receiver still on");

	c_ack_io: cover property (ack_cyc && bus_style_select);
	c_prom: cover property ($fell(prom_chip_select_n));
	c_hdr_end: cover property (hdr_store && hdr_last);
endmodule

bind lan_window_access lan_window_access_asserts chk (.clk, .sys_rst, .reg_rd, .reg_rdata,
	.reg_rvalid, .bus_style_select, .int_active, .interrupt_ack_n, .read_write,
	.io_read_strobe_n, .data_in, .data_oe_hi, .data_oe_lo, .prom_chip_select_n, .hdr_store,
	.hdr_last, .hdr_next_ptr, .hdr_ptr, .hdr_status, .rx_stopped, .rx_on);

//--- tb/lan_prom_model.sv
// Configuration PROM on the data bus.
// Assumes the address arrives on the upper data lines while selected.
`timescale 1ns/1ps
module lan_prom_model
(
	input  wire logic       clk,
	input  wire logic       prom_chip_select_n,
	input  wire logic [7:0] prom_addr,
	output logic [7:0]      prom_data
);
	logic [7:0] last_r = 8'h00;
	always_ff @(posedge clk)
	begin
		last_r <= prom_data;
	end
	// addressed byte on low lines
	// Released lines flip, so a stale byte never passes
	assign prom_data = prom_chip_select_n ? ~last_r : prom_addr ^ 8'hA5;
endmodule

//--- tb/lan_controller_window_access_tb.sv
// Bench for the buffer-window access block.
// Assumes a PROM model on the data bus; buffer memory returns its address low byte ^ 5A.
`timescale 1ns/1ps
module lan_controller_window_access_tb import lan_window_pkg::*;;
	logic        clk = 1'h0, sys_rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
	logic        bus_style_select = 1'h0, int_active = 1'h0, interrupt_ack_n = 1'h1;
	logic        read_write = 1'h0, io_read_strobe_n = 1'h1, rx_stopped = 1'h0;
	logic        hdr_store = 1'h0, hdr_last = 1'h0;
	logic [3:0]  reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000, hdr_next_ptr = 16'h0000, reg_rdata, data_out, hdr_ptr;
	logic [7:0]  prom_data, hdr_status, rx_start_high;
	logic        reg_rvalid, data_oe_hi, data_oe_lo, prom_chip_select_n, addr_two_byte, rx_on;
	logic [15:0] data_in;
	logic [15:0] mem_addr;
	logic [7:0]  mem_wdata, mem_rdata;
	logic [5:0]  station_enable;
	logic        mem_we, mem_re, tx_on, dma_on;
	assign mem_rdata = mem_addr[7:0] ^ 8'h5A;
	int          n_mismatch = 0, samples_checked = 0;
	assign data_in = {8'h00, prom_data};
	always #5 clk = ~clk;

	lan_window_access dut (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .reg_rvalid, .bus_style_select, .int_active, .interrupt_ack_n,
		.read_write, .io_read_strobe_n, .data_in, .data_out, .data_oe_hi, .data_oe_lo,
		.prom_chip_select_n, .mem_addr, .mem_wdata, .mem_we, .mem_re,
		.mem_rdata, .rx_stopped, .hdr_store, .hdr_last, .hdr_next_ptr, .hdr_ptr,
		.hdr_status, .rx_start_high, .station_enable, .addr_two_byte, .tx_on, .rx_on,
		.dma_on);
	lan_prom_model prom (.clk, .prom_chip_select_n, .prom_addr(data_out[15:8]), .prom_data);

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge clk);
		reg_wr <= 1'h0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		d = 16'hXXXX;
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge clk);
		reg_rd <= 1'h0;
		for (int i = 0; i < 8; i++)
		begin
			@(negedge clk);
			if (reg_rvalid === 1'h1)
			begin
				d = reg_rdata;
				break;
			end
		end
	endtask
	task automatic ack(input logic s, input logic rw, input logic [15:0] exp);
		@(posedge clk);
		bus_style_select <= s;
		int_active <= 1'h1;
		interrupt_ack_n <= 1'h0;
		read_write <= rw;
		io_read_strobe_n <= !s;
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk(data_oe_lo ? {8'h01, data_out[7:0]} : 16'h0000, exp);
		@(posedge clk);
		int_active <= 1'h0;
		interrupt_ack_n <= 1'h1;
		io_read_strobe_n <= 1'h1;
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk({15'h0000, data_oe_lo}, 16'h0000);
	endtask

	task automatic t_station();
		logic [15:0] d;
		wr(4'h4, 16'h0100);
		wr(4'h2, 16'h0402);
		for (int i = 0; i < 6; i++) wr(4'h8, 16'(16'h0010 + i));
		wr(4'h0, 16'h0200);
		wr(4'h0, 16'h1000);
		@(posedge clk) rx_stopped <= 1'h1;
		@(posedge clk) rx_stopped <= 1'h0;
		rd(4'h0, d);
		chk(d & 16'h0200, 16'h0000);
		wr(4'h2, 16'h0402);
		for (int i = 0; i < 6; i++)
		begin
			rd(4'h8, d);
			chk(d & 16'h00FF, 16'(16'h0010 + i));
		end
		chk({15'h0000, addr_two_byte}, 16'h0001);
		chk({10'h000, station_enable}, 16'h0004);
		$display("test station done");
	endtask
	task automatic t_tx_end();
		logic [15:0] d;
		wr(4'h2, 16'h0007);
		wr(4'h8, 16'h003C);
		rd(4'h8, d);
		chk(d & 16'h00FF, 16'h003C);
		chk({8'h00, rx_start_high}, 16'h003D);
		wr(4'hC, 16'hFF12);
		rd(4'hC, d);
		chk(d, 16'h3C12);
		wr(4'hC, 16'h2012);
		rd(4'hC, d);
		chk(d, 16'h2012);
		$display("test tx end done");
	endtask
	task automatic t_vector();
		logic [15:0] d;
		wr(4'h2, 16'h0009);
		wr(4'h8, 16'h00C7);
		rd(4'h8, d);
		chk(d & 16'h00FF, 16'h00C7);
		ack(1'h0, 1'h1, 16'h01C7);
		ack(1'h1, 1'h0, 16'h01C7);
		ack(1'h0, 1'h0, 16'h0000);
		$display("test vector done");
	endtask
	task automatic t_memory();
		logic [15:0] d;
		wr(4'h2, 16'h0008);
		wr(4'hE, 16'h3CFF);
		wr(4'h8, 16'h0055);
		@(negedge clk);
		chk({mem_we, mem_re, 6'h00, mem_wdata}, 16'h8055);
		chk(mem_addr, 16'h3CFF);
		// External access keeps the window busy for three cycles
		repeat (4) @(posedge clk);
		rd(4'hE, d);
		chk(d, 16'h0000);
		wr(4'hE, 16'h5012);
		wr(4'h8, 16'h0066);
		@(negedge clk);
		chk(mem_addr, 16'h3C12);
		repeat (4) @(posedge clk);
		wr(4'hE, 16'hFFFF);
		rd(4'h8, d);
		chk(d, 16'h00A5);
		chk(mem_addr, 16'hFFFF);
		rd(4'hE, d);
		chk(d, 16'h3D00);
		$display("test memory done");
	endtask
	task automatic t_prom();
		logic [15:0] d;
		wr(4'h0, 16'h0700);
		rd(4'h0, d);
		chk(d & 16'h0700, 16'h0700);
		wr(4'h0, 16'h3800);
		@(negedge clk);
		chk({13'h0000, tx_on, rx_on, dma_on}, 16'h0000);
		wr(4'hE, 16'h4141);
		wr(4'h2, 16'h0006);
		for (int i = 0; i < 3; i++)
		begin
			rd(4'h8, d);
			chk(d, 16'((16'h0041 + i) ^ 16'h00A5));
		end
		chk({15'h0000, prom_chip_select_n}, 16'h0001);
		$display("test prom done");
	endtask
	task automatic t_header();
		@(posedge clk);
		hdr_store <= 1'h1;
		hdr_next_ptr <= 16'h1234;
		@(posedge clk) hdr_last <= 1'h1;
		@(negedge clk);
		chk(hdr_ptr, 16'h1234);
		chk({8'h00, hdr_status}, 16'h0040);
		@(posedge clk) hdr_store <= 1'h0;
		@(negedge clk);
		chk(hdr_ptr | {8'h00, hdr_status}, 16'h0000);
		$display("test header done");
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial
	begin
		repeat (3) @(posedge clk);
		sys_rst <= 1'h0;
		t_station();
		t_tx_end();
		t_vector();
		t_memory();
		t_prom();
		t_header();
		give_verdict();
	end
	// Whole run needs well under a thousand cycles
	initial
	begin
		repeat (5000) @(posedge clk);
		n_mismatch++;
		give_verdict();
	end
endmodule
